// [bsmb_pkg.sv]
// package for the bridge secondary status and memory window block
// assumes a 16-bit configuration word port with byte-lane enables
`default_nettype none

package bsmb_pkg;

  // configuration port shape
  localparam int unsigned CFG_ADDR_W = 8;
  localparam int unsigned CFG_DATA_W = 16;
  localparam int unsigned CFG_BE_W   = 2;

  // register byte offsets, each register is one 16-bit word
  localparam logic [7:0] OFF_DOWNSTREAM_ERROR_STATUS = 8'h1E;
  localparam logic [7:0] OFF_MEM_WINDOW_BASE         = 8'h20;
  localparam logic [7:0] OFF_MEM_WINDOW_LIMIT        = 8'h22;

  // downstream_error_status field positions
  localparam int unsigned SEC_DETECTED_PERR_BIT = 15;
  localparam int unsigned SIGNALED_TA_BIT       = 11;
  localparam int unsigned SELECT_TIMING_HI      = 10;
  localparam int unsigned SELECT_TIMING_LO      = 9;
  localparam int unsigned SEC_MASTER_PERR_BIT   = 8;
  localparam int unsigned FAST_B2B_BIT          = 7;
  localparam int unsigned HIGH_SPEED_BIT        = 5;

  // memory window fields: register bits 15:4 carry address bits 31:20
  localparam int unsigned WIN_FIELD_W   = 12;
  localparam int unsigned WIN_FIELD_LSB = 4;
  localparam int unsigned WIN_ADDR_LSB  = 20;

  // decode fill for the unimplemented low address bits
  localparam logic [19:0] WIN_BASE_FILL  = 20'h00000;
  localparam logic [19:0] WIN_LIMIT_FILL = 20'hFFFFF;

  // reset values
  localparam logic [11:0] WIN_FIELD_RST = 12'h000;
  localparam logic        FLAG_RST      = 1'b0;

  // hardwired read values
  localparam logic [1:0] SELECT_TIMING_VAL = 2'h0;
  localparam logic       FAST_B2B_VAL      = 1'b0;
  localparam logic       HIGH_SPEED_VAL    = 1'b0;
  localparam logic [3:0] WIN_LOW_NIBBLE    = 4'h0;

endpackage

`default_nettype wire

// [bsmb_window_dec.sv]
// address window comparator for the non-prefetchable memory window
// assumes base and limit fields are stable register outputs
`default_nettype none

module bsmb_window_dec (
  // programmed window fields, address bits 31:20
  input  wire logic [11:0] i_base,
  input  wire logic [11:0] i_limit,
  // access under decode
  input  wire logic [31:0] i_addr,
  // window hit, combinational
  output logic             o_hit
);
  import bsmb_pkg::*;

  logic [31:0] base_full;
  logic [31:0] limit_full;

  // expand fields; base starts on a 1 MB boundary, limit ends just below one
  assign base_full  = {i_base, WIN_BASE_FILL};
  assign limit_full = {i_limit, WIN_LIMIT_FILL};

  // inclusive compare at both ends; overlap with other windows is not checked
  assign o_hit = (i_addr >= base_full) && (i_addr <= limit_full);

endmodule

`default_nettype wire

// [bsmb_bridge_regs.sv]
// secondary status word, parity logging and memory window decode
// assumes event inputs are one-cycle pulses synchronous to I_MCLK
`default_nettype none

module bsmb_bridge_regs (
  // clock and reset
  input  wire logic                              I_MCLK,
  input  wire logic                              I_RESETN,
  // configuration word port
  input  wire logic [bsmb_pkg::CFG_ADDR_W-1:0]   I_CFG_ADDR,
  input  wire logic                              I_CFG_WR,
  input  wire logic                              I_CFG_RD,
  input  wire logic [bsmb_pkg::CFG_BE_W-1:0]     I_CFG_BE,
  input  wire logic [bsmb_pkg::CFG_DATA_W-1:0]   I_CFG_WDATA,
  output logic      [bsmb_pkg::CFG_DATA_W-1:0]   O_CFG_RDATA,
  output logic                                   O_CFG_RVALID,
  // bridge control and primary state
  input  wire logic                              I_PARITY_ERROR_RESPONSE_ENABLE,
  input  wire logic                              I_PRIMARY_RECEIVED_TARGET_ABORT,
  // port events, one-cycle pulses
  input  wire logic                              I_CA_CPL_SENT,
  input  wire logic                              I_IB_POSTED_POISONED,
  input  wire logic                              I_IB_CPL_POISONED,
  input  wire logic                              I_TX_WRITE_POISONED,
  input  wire logic                              I_OB_POSTED_PERR,
  input  wire logic                              I_OB_CPL_PERR,
  // primary status parity flags, cleared by their owner
  input  wire logic                              I_PRI_DPE_CLR,
  input  wire logic                              I_PRI_MDPE_CLR,
  output logic                                   O_PRI_DETECTED_PARITY_ERROR,
  output logic                                   O_PRI_MASTER_DATA_PARITY_ERROR,
  // memory access decode
  input  wire logic                              I_MEM_VALID,
  input  wire logic                              I_MEM_NONPREF,
  input  wire logic [31:0]                       I_MEM_ADDR,
  output logic                                   O_ROUTE_TO_PORT
);
  import bsmb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic        secondary_detected_parity_error_reg;
  logic        sta_reg;
  logic        smdpe_reg;
  logic        pri_dpe_reg;
  logic        pri_mdpe_reg;
  logic [11:0] base_reg;
  logic [11:0] limit_reg;
  logic [15:0] rdata_next;
  logic        rd_sec_reg;
  logic        rd_win_reg;
  logic        win_hit;
  logic        wr_sec;
  logic        wr_base;
  logic        wr_limit;
  logic        sta_set;
  logic        smdpe_set;
  logic        secondary_detected_parity_error_set;
  logic [15:0] sec_status_word;

  // word match on the upper address bits; bit 0 is ignored, the byte enables select the lane
  function automatic logic hits_word(input logic [7:0] addr, input logic [7:0] off);
    hits_word = (addr[7:1] == off[7:1]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access decode and event terms

  // write selects per register
  assign wr_sec   = I_CFG_WR && hits_word(I_CFG_ADDR, OFF_DOWNSTREAM_ERROR_STATUS);
  assign wr_base  = I_CFG_WR && hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_BASE);
  assign wr_limit = I_CFG_WR && hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_LIMIT);

  // only completions passed down from the primary side can signal an abort
  assign sta_set   = I_CA_CPL_SENT && I_PRIMARY_RECEIVED_TARGET_ABORT;
  // master parity logs inbound completions and own poisoned writes, gated
  assign smdpe_set = I_PARITY_ERROR_RESPONSE_ENABLE &&
                     (I_IB_CPL_POISONED || I_TX_WRITE_POISONED);
  // detected parity logs every inbound poisoned packet, never gated
  assign secondary_detected_parity_error_set  = I_IB_POSTED_POISONED || I_IB_CPL_POISONED;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags, set wins over a same-cycle clear

  // detected parity error
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      secondary_detected_parity_error_reg <= FLAG_RST;
    end else if (secondary_detected_parity_error_set) begin
      secondary_detected_parity_error_reg <= 1'b1;
    end else if (wr_sec && I_CFG_BE[1] && I_CFG_WDATA[SEC_DETECTED_PERR_BIT]) begin
      secondary_detected_parity_error_reg <= 1'b0;
    end
  end

  // signaled target abort
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      sta_reg <= FLAG_RST;
    end else if (sta_set) begin
      sta_reg <= 1'b1;
    end else if (wr_sec && I_CFG_BE[1] && I_CFG_WDATA[SIGNALED_TA_BIT]) begin
      sta_reg <= 1'b0;
    end
  end

  // secondary master data parity error
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      smdpe_reg <= FLAG_RST;
    end else if (smdpe_set) begin
      smdpe_reg <= 1'b1;
    end else if (wr_sec && I_CFG_BE[1] && I_CFG_WDATA[SEC_MASTER_PERR_BIT]) begin
      smdpe_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // primary side parity logging

  // detected parity covers both outbound kinds, so it is a superset here
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      pri_dpe_reg <= FLAG_RST;
    end else if (I_OB_POSTED_PERR || I_OB_CPL_PERR) begin
      pri_dpe_reg <= 1'b1;
    end else if (I_PRI_DPE_CLR) begin
      pri_dpe_reg <= 1'b0;
    end
  end

  // master parity logs outbound completions only
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      pri_mdpe_reg <= FLAG_RST;
    end else if (I_OB_CPL_PERR) begin
      pri_mdpe_reg <= 1'b1;
    end else if (I_PRI_MDPE_CLR) begin
      pri_mdpe_reg <= 1'b0;
    end
  end

  assign O_PRI_DETECTED_PARITY_ERROR    = pri_dpe_reg;
  assign O_PRI_MASTER_DATA_PARITY_ERROR = pri_mdpe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // memory window fields

  // base field, upper lane holds address bits 31:24, lower lane 23:20
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      base_reg <= WIN_FIELD_RST;
    end else if (wr_base) begin
      if (I_CFG_BE[1]) begin
        base_reg[11:4] <= I_CFG_WDATA[15:8];
      end
      if (I_CFG_BE[0]) begin
        base_reg[3:0] <= I_CFG_WDATA[7:4];
      end
    end
  end

  // limit field, same layout as the base
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      limit_reg <= WIN_FIELD_RST;
    end else if (wr_limit) begin
      if (I_CFG_BE[1]) begin
        limit_reg[11:4] <= I_CFG_WDATA[15:8];
      end
      if (I_CFG_BE[0]) begin
        limit_reg[3:0] <= I_CFG_WDATA[7:4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // hardwired and reserved bits are constants, so writes cannot reach them
  always_comb begin
    sec_status_word = 16'h0000;
    sec_status_word[SEC_DETECTED_PERR_BIT] = secondary_detected_parity_error_reg;
    sec_status_word[SIGNALED_TA_BIT] = sta_reg;
    sec_status_word[SELECT_TIMING_HI:SELECT_TIMING_LO] = SELECT_TIMING_VAL;
    sec_status_word[SEC_MASTER_PERR_BIT] = smdpe_reg;
    sec_status_word[FAST_B2B_BIT] = FAST_B2B_VAL;
    sec_status_word[HIGH_SPEED_BIT] = HIGH_SPEED_VAL;
  end

  // word select, unmapped offsets read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (hits_word(I_CFG_ADDR, OFF_DOWNSTREAM_ERROR_STATUS)) begin
      rdata_next = sec_status_word;
    end else if (hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_BASE)) begin
      rdata_next = {base_reg, WIN_LOW_NIBBLE};
    end else if (hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_LIMIT)) begin
      rdata_next = {limit_reg, WIN_LOW_NIBBLE};
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      O_CFG_RDATA  <= 16'h0000;
      O_CFG_RVALID <= 1'b0;
    end else begin
      O_CFG_RVALID <= I_CFG_RD;
      if (I_CFG_RD) begin
        O_CFG_RDATA <= rdata_next;
      end
    end
  end

  // marks which word a read in the previous cycle targeted, cleared in a cycle after no read
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      rd_sec_reg <= 1'b0;
      rd_win_reg <= 1'b0;
    end else begin
      rd_sec_reg <= I_CFG_RD && hits_word(I_CFG_ADDR, OFF_DOWNSTREAM_ERROR_STATUS);
      rd_win_reg <= I_CFG_RD && (hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_BASE) ||
                                 hits_word(I_CFG_ADDR, OFF_MEM_WINDOW_LIMIT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // downstream decode

  bsmb_window_dec u_dec (
    .i_base  (base_reg),
    .i_limit (limit_reg),
    .i_addr  (I_MEM_ADDR),
    .o_hit   (win_hit)
  );

  // registered routing; an empty window (base above limit) never hits
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      O_ROUTE_TO_PORT <= 1'b0;
    end else begin
      O_ROUTE_TO_PORT <= I_MEM_VALID && I_MEM_NONPREF && win_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  property p_sta_set;
    sta_set |=> sta_reg;
  endproperty
  a_sta_set: assert property (p_sta_set)
    else $error("signaled abort not set");

  property p_sta_cause;
    $rose(sta_reg) |-> $past(I_CA_CPL_SENT) && $past(I_PRIMARY_RECEIVED_TARGET_ABORT);
  endproperty
  a_sta_cause: assert property (p_sta_cause)
    else $error("signaled abort set without passed abort");

  property p_timing_zero;
    O_CFG_RVALID && rd_sec_reg |-> O_CFG_RDATA[10:9] == 2'h0;
  endproperty
  a_timing_zero: assert property (p_timing_zero)
    else $error("select timing bits not zero");

  property p_smdpe_cpl;
    I_PARITY_ERROR_RESPONSE_ENABLE && I_IB_CPL_POISONED |=> smdpe_reg;
  endproperty
  a_smdpe_cpl: assert property (p_smdpe_cpl)
    else $error("poisoned completion not logged");

  property p_smdpe_tx;
    I_PARITY_ERROR_RESPONSE_ENABLE && I_TX_WRITE_POISONED |=> smdpe_reg;
  endproperty
  a_smdpe_tx: assert property (p_smdpe_tx)
    else $error("own poisoned write not logged");

  property p_smdpe_gate;
    $rose(smdpe_reg) |-> $past(I_PARITY_ERROR_RESPONSE_ENABLE);
  endproperty
  a_smdpe_gate: assert property (p_smdpe_gate)
    else $error("master parity set while response disabled");

  property p_w1c;
    wr_sec && I_CFG_BE[1] && I_CFG_WDATA[SIGNALED_TA_BIT] && !sta_set |=> !sta_reg;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("signaled abort did not clear");

  property p_fixed_bits;
    O_CFG_RVALID && rd_sec_reg |-> O_CFG_RDATA[7] == 1'b0;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fast back-to-back bit not zero");

  property p_high_speed;
    O_CFG_RVALID && rd_sec_reg |-> !O_CFG_RDATA[5];
  endproperty
  a_high_speed: assert property (p_high_speed)
    else $error("high speed bit not zero");

  property p_reserved;
    O_CFG_RVALID && rd_sec_reg |-> O_CFG_RDATA[6] == 1'b0 && O_CFG_RDATA[4:0] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits not zero");

  property p_secondary_detected_parity_error_cause;
    $rose(secondary_detected_parity_error_reg) |-> $past(I_IB_POSTED_POISONED || I_IB_CPL_POISONED);
  endproperty
  a_secondary_detected_parity_error_cause: assert property (p_secondary_detected_parity_error_cause)
    else $error("detected parity set by non-inbound traffic");

  property p_pri_cpl;
    I_OB_CPL_PERR |=> O_PRI_DETECTED_PARITY_ERROR && O_PRI_MASTER_DATA_PARITY_ERROR;
  endproperty
  a_pri_cpl: assert property (p_pri_cpl)
    else $error("outbound completion error not logged");

  property p_win_nibble;
    O_CFG_RVALID && rd_win_reg |-> O_CFG_RDATA[3:0] == 4'h0;
  endproperty
  a_win_nibble: assert property (p_win_nibble)
    else $error("window low nibble not zero");

  property p_route;
    I_MEM_VALID && I_MEM_NONPREF && (I_MEM_ADDR[31:20] >= base_reg) &&
      (I_MEM_ADDR[31:20] <= limit_reg) |=> O_ROUTE_TO_PORT;
  endproperty
  a_route: assert property (p_route)
    else $error("in-window access not routed");

  property p_route_cause;
    O_ROUTE_TO_PORT |-> $past(I_MEM_VALID) && $past(I_MEM_NONPREF);
  endproperty
  a_route_cause: assert property (p_route_cause)
    else $error("route without valid non-prefetchable access");

  property p_secondary_detected_parity_error_any;
    secondary_detected_parity_error_set |=> secondary_detected_parity_error_reg;
  endproperty
  a_secondary_detected_parity_error_any: assert property (p_secondary_detected_parity_error_any)
    else $error("inbound poisoned packet not logged");

  property p_reset;
    disable iff (1'b0)
    !I_RESETN |=> !sta_reg && !smdpe_reg && !secondary_detected_parity_error_reg && base_reg == 12'h000;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear state");

endmodule

`default_nettype wire

// [bsmb_link_partner.sv]
// link partner model: sends poisoned posted or completion packets
// assumes one request at a time; a new request restarts the wait
`default_nettype none

module bsmb_link_partner (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // send request, kind 0 posted, 1 completion, wait cycles before arrival
  input  wire logic       i_send,
  input  wire logic       i_kind,
  input  wire logic [3:0] i_wait,
  // poisoned packet arrival, one-cycle pulses
  output logic            o_posted_poisoned,
  output logic            o_cpl_poisoned
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] cnt_reg;
  logic       kind_reg;

  ////////////////////////////////////////////////////////////////////////////
  // delay counter so the partner can answer promptly or slowly
  always_ff @(posedge i_clk) begin
    o_posted_poisoned <= 1'b0;
    o_cpl_poisoned    <= 1'b0;
    if (!i_rst_n) begin
      cnt_reg  <= 5'h00;
      kind_reg <= 1'b0;
    end else if (i_send) begin
      cnt_reg  <= {1'b0, i_wait} + 5'h01;
      kind_reg <= i_kind;
    end else if (cnt_reg == 5'h01) begin
      cnt_reg           <= 5'h00;
      o_posted_poisoned <= !kind_reg;
      o_cpl_poisoned    <= kind_reg;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
endmodule

`default_nettype wire

// [bsmb_bridge_regs_tb.sv]
// self-checking bench for the secondary status and memory window block
// assumes config reads answer one cycle after the read edge
`default_nettype none

module bsmb_bridge_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rvalid;
  logic [7:0]  addr = 8'h00;
  logic [1:0]  be_s = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic        pen = 1'b0, rta = 1'b0, ca = 1'b0, txp = 1'b0, obp = 1'b0, obc = 1'b0;
  logic        pdclr = 1'b0, pmclr = 1'b0, pri_dpe, pri_mdpe, route;
  logic        mvalid = 1'b0, nonpref = 1'b0, send = 1'b0, kind = 1'b0;
  logic [31:0] maddr = 32'h0000_0000;
  logic [3:0]  lwait = 4'h0;
  logic        ib_post, ib_cpl;
  int          fail_count = 0, samples_checked = 0;

  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // design and far-side model
  bsmb_bridge_regs u_bsmb_bridge_regs (
    .I_MCLK(mclk), .I_RESETN(resetn), .I_CFG_ADDR(addr), .I_CFG_WR(wr),
    .I_CFG_RD(rd), .I_CFG_BE(be_s), .I_CFG_WDATA(wdata), .O_CFG_RDATA(rdata),
    .O_CFG_RVALID(rvalid), .I_PARITY_ERROR_RESPONSE_ENABLE(pen),
    .I_PRIMARY_RECEIVED_TARGET_ABORT(rta), .I_CA_CPL_SENT(ca),
    .I_IB_POSTED_POISONED(ib_post), .I_IB_CPL_POISONED(ib_cpl),
    .I_TX_WRITE_POISONED(txp), .I_OB_POSTED_PERR(obp), .I_OB_CPL_PERR(obc),
    .I_PRI_DPE_CLR(pdclr), .I_PRI_MDPE_CLR(pmclr),
    .O_PRI_DETECTED_PARITY_ERROR(pri_dpe), .O_PRI_MASTER_DATA_PARITY_ERROR(pri_mdpe),
    .I_MEM_VALID(mvalid), .I_MEM_NONPREF(nonpref), .I_MEM_ADDR(maddr),
    .O_ROUTE_TO_PORT(route));

  bsmb_link_partner u_bsmb_link_partner (
    .i_clk(mclk), .i_rst_n(resetn), .i_send(send), .i_kind(kind), .i_wait(lwait),
    .o_posted_poisoned(ib_post), .o_cpl_poisoned(ib_cpl));

  ////////////////////////////////////////////////////////////////////////////
  // access and compare tasks; inputs change 1 ns after the rising edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic bad(input string m);
    fail_count++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("word got %h want %h", got, exp));
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) bad($sformatf("%s got %b want %b", what, got, exp));
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    addr  = a;
    be_s  = b;
    wdata = d;
    wr    = 1'b1;
    tick();
    wr    = 1'b0;
    // let an edge pass so a following call never re-raises the strobe in this step
    tick();
  endtask

  // bounded wait for the read answer
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    int n;
    n    = 0;
    addr = a;
    rd   = 1'b1;
    tick();
    rd   = 1'b0;
    while (rvalid !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    if (rvalid !== 1'b1) bad("no read answer");
    cmp16(rdata, exp);
    tick();
  endtask

  // one-cycle pulse on a bench-driven event: 0 abort cpl, 1 own poisoned
  // write, 2 ob posted, 3 ob cpl, 4 primary detected clear, 5 master clear
  task automatic ev(input int k);
    {ca, txp, obp, obc, pdclr, pmclr} = 6'b100000 >> k;
    tick();
    {ca, txp, obp, obc, pdclr, pmclr} = 6'b000000;
    tick();
  endtask

  // partner sends one poisoned packet after w cycles
  task automatic lp(input logic k, input logic [3:0] w);
    int n;
    n     = 0;
    kind  = k;
    lwait = w;
    send  = 1'b1;
    tick();
    send  = 1'b0;
    while (ib_post !== 1'b1 && ib_cpl !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    if (n == 20) bad("partner silent");
    tick();
  endtask

  task automatic dec(input logic [31:0] a, input logic v, input logic np, input logic exp);
    maddr   = a;
    mvalid  = v;
    nonpref = np;
    tick();
    mvalid  = 1'b0;
    cmp1(route, exp, "route");
    tick();
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the roughly 130 cycles the tests need
  initial begin
    #100000;
    bad("watchdog");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
    tick();
    chk_rd(8'h1E, 16'h0000);
    chk_rd(8'h20, 16'h0000);
    chk_rd(8'h22, 16'h0000);
    // hardwired and reserved status bits ignore writes
    cfg_wr(8'h1E, 2'h3, 16'hFFFF);
    chk_rd(8'h1E, 16'h0000);
    cfg_wr(8'h20, 2'h3, 16'hFFFF);
    chk_rd(8'h20, 16'hFFF0);
    cfg_wr(8'h22, 2'h3, 16'hFFFF);
    chk_rd(8'h22, 16'hFFF0);
    cfg_wr(8'h24, 2'h3, 16'h5A5A);
    chk_rd(8'h24, 16'h0000);
    // poisoned traffic with response disabled, then enabled
    lp(1'b1, 4'h0);
    ev(1);
    chk_rd(8'h1E, 16'h8000);
    cfg_wr(8'h1E, 2'h3, 16'hFFFF);
    chk_rd(8'h1E, 16'h0000);
    pen = 1'b1;
    lp(1'b1, 4'h9);
    chk_rd(8'h1E, 16'h8100);
    cfg_wr(8'h1E, 2'h3, 16'h0100);
    chk_rd(8'h1E, 16'h8000);
    cfg_wr(8'h1E, 2'h3, 16'h8000);
    lp(1'b0, 4'h3);
    chk_rd(8'h1E, 16'h8000);
    cfg_wr(8'h1E, 2'h3, 16'hFFFF);
    ev(1);
    chk_rd(8'h1E, 16'h0100);
    cfg_wr(8'h1E, 2'h3, 16'hFFFF);
    // completer abort gated by the primary abort flag
    ev(0);
    chk_rd(8'h1E, 16'h0000);
    rta = 1'b1;
    ev(0);
    chk_rd(8'h1E, 16'h0800);
    cfg_wr(8'h1E, 2'h1, 16'hFFFF);
    chk_rd(8'h1E, 16'h0800);
    cfg_wr(8'h1E, 2'h2, 16'h0800);
    chk_rd(8'h1E, 16'h0000);
    // primary logging matrix
    ev(2);
    cmp1(pri_dpe, 1'b1, "pri dpe");
    cmp1(pri_mdpe, 1'b0, "pri mdpe");
    ev(4);
    ev(3);
    cmp1(pri_dpe, 1'b1, "pri dpe");
    cmp1(pri_mdpe, 1'b1, "pri mdpe");
    chk_rd(8'h1E, 16'h0000);
    ev(4);
    ev(5);
    cmp1(pri_dpe | pri_mdpe, 1'b0, "pri clear");
    // window 100h..1FFh, edges of both fills
    cfg_wr(8'h20, 2'h3, 16'h1000);
    cfg_wr(8'h22, 2'h3, 16'h1FF0);
    dec(32'h0FFF_FFFF, 1'b1, 1'b1, 1'b0);
    dec(32'h1000_0000, 1'b1, 1'b1, 1'b1);
    dec(32'h1FFF_FFFF, 1'b1, 1'b1, 1'b1);
    dec(32'h2000_0000, 1'b1, 1'b1, 1'b0);
    dec(32'h1800_0000, 1'b1, 1'b0, 1'b0);
    dec(32'h1800_0000, 1'b0, 1'b1, 1'b0);
    // second reset in mid-run with flags set
    ev(0);
    ev(2);
    resetn = 1'b0;
    tick();
    resetn = 1'b1;
    tick();
    chk_rd(8'h1E, 16'h0000);
    chk_rd(8'h20, 16'h0000);
    cmp1(pri_dpe, 1'b0, "pri dpe");
    tally_and_finish();
  end
endmodule

`default_nettype wire
